// ### core/apmc_pkg.sv
// Package for the audio port and modulator configuration block.
// Assumes one system clock domain and one audio bit-clock domain.
package apmc_pkg;

    // Register map
    localparam logic [7:0] MOD_CFG_OFFSET = 8'h02;
    localparam logic [7:0] SAP_CFG_OFFSET = 8'h03;
    localparam logic [7:0] STATUS_OFFSET = 8'h30;
    localparam logic [7:0] MOD_CFG_RESET = 8'h62;
    localparam logic [7:0] SAP_CFG_RESET = 8'h04;
    localparam logic [7:0] MOD_CFG_WMASK = 8'h77;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Serial audio port configuration, laid out as the register
    typedef struct packed {
        logic [1:0] rate;
        logic slot_group;
        logic slot16;
        logic swap;
        logic [2:0] format;
    } apmc_sap_cfg_t;

    // Modulator switching configuration, laid out as the register
    typedef struct packed {
        logic rsv7;
        logic [2:0] pwm_freq;
        logic rsv3;
        logic osr;
        logic [1:0] phase;
    } apmc_mod_cfg_t;

    // Input formats
    localparam logic [2:0] FMT_RJ24 = 3'h0;
    localparam logic [2:0] FMT_RJ20 = 3'h1;
    localparam logic [2:0] FMT_RJ18 = 3'h2;
    localparam logic [2:0] FMT_RJ16 = 3'h3;
    localparam logic [2:0] FMT_I2S = 3'h4;
    localparam logic [2:0] FMT_LJ = 3'h5;
    localparam logic [2:0] FMT_TDM = 3'h6;

    // Sample rates
    localparam logic [1:0] RATE_44K1 = 2'h0;
    localparam logic [1:0] RATE_48K = 2'h1;
    localparam logic [1:0] RATE_96K = 2'h2;
    localparam logic [16:0] FS_44K1_HZ = 17'h0_AC44;
    localparam logic [16:0] FS_48K_HZ = 17'h0_BB80;
    localparam logic [16:0] FS_96K_HZ = 17'h1_7700;

    // Switching frequency codes and multiples of fs
    localparam logic [2:0] PWM_X8 = 3'h0;
    localparam logic [2:0] PWM_X10 = 3'h1;
    localparam logic [2:0] PWM_X38 = 3'h5;
    localparam logic [2:0] PWM_X44 = 3'h6;
    localparam logic [2:0] PWM_X48 = 3'h7;
    localparam logic [5:0] MULT_8 = 6'h08;
    localparam logic [5:0] MULT_10 = 6'h0A;
    localparam logic [5:0] MULT_38 = 6'h26;
    localparam logic [5:0] MULT_44 = 6'h2C;
    localparam logic [5:0] MULT_48 = 6'h30;

    // Oversampling ratios and phase offsets in degrees
    localparam logic [7:0] OSR_64 = 8'h40;
    localparam logic [7:0] OSR_128 = 8'h80;
    localparam logic [5:0] PHASE_0 = 6'h00;
    localparam logic [5:0] PHASE_30 = 6'h1E;
    localparam logic [5:0] PHASE_45 = 6'h2D;
    localparam logic [5:0] PHASE_60 = 6'h3C;

    // Serial framing
    localparam int SAMPLE_W = 24;
    localparam int NUM_CH = 4;
    localparam logic [8:0] SLOT_STRIDE_WIDE = 9'h020;
    localparam logic [8:0] SLOT_STRIDE_16 = 9'h010;
    localparam logic [8:0] CNT_MAX = 9'h1FF;
    localparam logic [2:0] GROUP_BASE_HI = 3'h4;

    // Status register bits
    localparam int ST_CFG_BUSY = 0;
    localparam int ST_FRAME_SEEN = 1;
    localparam int ST_FALLBACK = 2;

    typedef logic [NUM_CH-1:0][SAMPLE_W-1:0] apmc_frame_t;

endpackage : apmc_pkg

// ### core/apmc_sap_rx.sv
// Serial audio receiver on the bit clock: deframes four channels.
// Assumes frame sync and data pins change on the falling bit-clock edge.
module apmc_sap_rx
(
    // Link clock and reset
    input wire logic sclk_i,
    input wire logic rstn_link_i,
    // Pins
    input wire logic fsync_i,
    input wire logic [1:0] sdata_i,
    // Configuration already in this domain
    input wire apmc_pkg::apmc_sap_cfg_t cfg_i,
    // Deframed samples
    output apmc_pkg::apmc_frame_t frame_o,
    output logic frame_tgl_o
);

    logic fs_d_reg;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic [31:0] sr0_reg;
    logic [31:0] sr1_reg;
    apmc_pkg::apmc_frame_t ch_reg;
    apmc_pkg::apmc_frame_t ch_next;
    apmc_pkg::apmc_frame_t frame_reg;
    logic tgl_reg;

    wire is_tdm = (cfg_i.format == apmc_pkg::FMT_TDM);
    wire is_i2s = (cfg_i.format == apmc_pkg::FMT_I2S);
    wire is_rj = (cfg_i.format[2] == 1'b0);
    wire fs_edge = (fsync_i != fs_d_reg);
    wire fs_rise = fsync_i & ~fs_d_reg;
    wire start = is_tdm ? fs_rise : fs_edge;
    // Left half is low for I2S, high for justified formats
    wire left_now = is_i2s ? ~fsync_i : fsync_i;
    wire left_old = is_i2s ? ~fs_d_reg : fs_d_reg;
    wire frame_start = is_tdm ? fs_rise : (fs_edge & left_now);
    wire [8:0] delay = (is_i2s | is_tdm) ? 9'h001 : 9'h000;
    // Old count still places the last TDM slot bit
    wire [8:0] cnt_inc = (cnt_reg == apmc_pkg::CNT_MAX) ? cnt_reg : cnt_reg + 9'h001;
    wire [8:0] pos_all = cnt_inc - delay;
    wire [8:0] stride = cfg_i.slot16 ? apmc_pkg::SLOT_STRIDE_16
                                     : apmc_pkg::SLOT_STRIDE_WIDE;
    wire [8:0] bits = (is_tdm & cfg_i.slot16) ? 9'h010 : 9'h018;
    wire [8:0] slot = is_tdm ? (cfg_i.slot16 ? {4'h0, pos_all[8:4]}
                                             : {5'h00, pos_all[8:5]}) : 9'h000;
    wire [8:0] pos = is_tdm ? (pos_all & (stride - 9'h001)) : pos_all;
    wire [2:0] base = cfg_i.slot_group ? apmc_pkg::GROUP_BASE_HI : 3'h0;
    wire [2:0] slot_rel = slot[2:0] - base;
    wire in_group = (slot[8:3] == 6'h00) && (slot[2] == base[2]);
    wire la_hit = ~is_rj && (cnt_inc >= delay) && (pos == bits - 9'h001);
    wire [23:0] la_w0 = ~bits[3] ? {sr0_reg[14:0], sdata_i[0], 8'h00}
                                : {sr0_reg[22:0], sdata_i[0]};
    wire [23:0] la_w1 = {sr1_reg[22:0], sdata_i[1]};

    // Right-justified words end at the half boundary, so take the last bits
    function automatic logic [23:0] rj_word(input logic [31:0] sr, input logic [2:0] fmt);
        case (fmt)
            apmc_pkg::FMT_RJ20: rj_word = {sr[19:0], 4'h0};
            apmc_pkg::FMT_RJ18: rj_word = {sr[17:0], 6'h00};
            apmc_pkg::FMT_RJ16: rj_word = {sr[15:0], 8'h00};
            default: rj_word = sr[23:0];
        endcase
    endfunction : rj_word

    assign cnt_next = start ? 9'h000 : cnt_inc;

    always_comb
    begin
        ch_next = ch_reg;
        if (is_rj && fs_edge)
        begin
            ch_next[left_old ? 0 : 1] = rj_word(sr0_reg, cfg_i.format);
            ch_next[left_old ? 2 : 3] = rj_word(sr1_reg, cfg_i.format);
        end
        else if (la_hit && is_tdm)
        begin
            if (in_group)
            begin
                ch_next[slot_rel[1:0]] = la_w0;
            end
        end
        else if (la_hit)
        begin
            ch_next[left_now ? 0 : 1] = la_w0;
            ch_next[left_now ? 2 : 3] = la_w1;
        end
    end

    always_ff @(posedge sclk_i or negedge rstn_link_i)
    begin
        if (!rstn_link_i)
        begin
            fs_d_reg <= 1'b0;
            cnt_reg <= 9'h000;
            sr0_reg <= 32'h0000_0000;
            sr1_reg <= 32'h0000_0000;
            ch_reg <= '0;
        end
        else
        begin
            fs_d_reg <= fsync_i;
            cnt_reg <= cnt_next;
            sr0_reg <= {sr0_reg[30:0], sdata_i[0]};
            sr1_reg <= {sr1_reg[30:0], sdata_i[1]};
            ch_reg <= ch_next;
        end
    end

    // Frame is held for a whole frame period, long enough for the crossing
    always_ff @(posedge sclk_i or negedge rstn_link_i)
    begin
        if (!rstn_link_i)
        begin
            frame_reg <= '0;
            tgl_reg <= 1'b0;
        end
        else if (frame_start)
        begin
            frame_reg <= cfg_i.swap ? {ch_next[1], ch_next[0], ch_next[3], ch_next[2]}
                                    : ch_next;
            tgl_reg <= ~tgl_reg;
        end
    end

    assign frame_o = frame_reg;
    assign frame_tgl_o = tgl_reg;

endmodule : apmc_sap_rx

// ### core/apmc_top.sv
// Audio port and modulator configuration: registers, crossings, receiver.
// Assumes a single-cycle register port on mclk and a bit clock from the source.
module apmc_top
(
    // System clock and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Serial audio link
    input wire logic sclk_i,
    input wire logic fsync_i,
    input wire logic [1:0] sdata_i,
    // Modulator settings in effect
    output logic [5:0] pwm_mult_o,
    output logic [7:0] sigma_delta_oversampling_select_o,
    output logic [5:0] phase_deg_o,
    output logic [16:0] fs_hz_o,
    // Received channels
    output apmc_pkg::apmc_frame_t frame_o,
    output logic frame_valid_o
);

    // Register file
    apmc_pkg::apmc_sap_cfg_t sap_cfg_reg;
    apmc_pkg::apmc_mod_cfg_t mod_cfg_reg;
    logic [7:0] rdata_reg;
    logic frame_seen_reg;

    // Effective decode
    apmc_pkg::apmc_sap_cfg_t sap_eff;
    logic [5:0] pwm_mult_reg;
    logic [7:0] osr_reg;
    logic [5:0] phase_reg;
    logic [16:0] fs_hz_reg;

    // Configuration crossing, system side
    apmc_pkg::apmc_sap_cfg_t cfg_hold_reg;
    logic req_tgl_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;

    // Configuration crossing, link side
    logic rst_l1_reg;
    logic rst_l2_reg;
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_seen_reg;
    apmc_pkg::apmc_sap_cfg_t cfg_link_reg;

    // Frame crossing
    apmc_pkg::apmc_frame_t rx_frame;
    logic rx_tgl;
    logic frm_s1_reg;
    logic frm_s2_reg;
    logic frm_s3_reg;
    apmc_pkg::apmc_frame_t frame_reg;
    logic frame_valid_reg;

    // Reserved codes never reach the datapath
    function automatic logic [2:0] safe_format(input logic [2:0] fmt);
        safe_format = (fmt == 3'h7) ? apmc_pkg::FMT_I2S : fmt;
    endfunction : safe_format

    function automatic logic [1:0] safe_rate(input logic [1:0] rate);
        safe_rate = (rate == 2'h3) ? apmc_pkg::RATE_44K1 : rate;
    endfunction : safe_rate

    // 48x is not allowed at 48 kHz; reserved codes hold the reset multiple
    function automatic logic [5:0] pwm_mult(input logic [2:0] code, input logic [1:0] rate);
        case (code)
            apmc_pkg::PWM_X8: pwm_mult = apmc_pkg::MULT_8;
            apmc_pkg::PWM_X10: pwm_mult = apmc_pkg::MULT_10;
            apmc_pkg::PWM_X38: pwm_mult = apmc_pkg::MULT_38;
            apmc_pkg::PWM_X48: pwm_mult = (rate == apmc_pkg::RATE_48K) ? apmc_pkg::MULT_44
                                                                      : apmc_pkg::MULT_48;
            default: pwm_mult = apmc_pkg::MULT_44;
        endcase
    endfunction : pwm_mult

    function automatic logic [5:0] phase_deg(input logic [1:0] code);
        case (code)
            2'h0: phase_deg = apmc_pkg::PHASE_0;
            2'h1: phase_deg = apmc_pkg::PHASE_30;
            2'h2: phase_deg = apmc_pkg::PHASE_45;
            default: phase_deg = apmc_pkg::PHASE_60;
        endcase
    endfunction : phase_deg

    // Rate in hertz, for the modulator timing
    function automatic logic [16:0] fs_hz(input logic [1:0] rate);
        case (rate)
            apmc_pkg::RATE_48K: fs_hz = apmc_pkg::FS_48K_HZ;
            apmc_pkg::RATE_96K: fs_hz = apmc_pkg::FS_96K_HZ;
            default: fs_hz = apmc_pkg::FS_44K1_HZ;
        endcase
    endfunction : fs_hz

    // Address decode
    wire sel_mod = (reg_addr_i == apmc_pkg::MOD_CFG_OFFSET);
    wire sel_sap = (reg_addr_i == apmc_pkg::SAP_CFG_OFFSET);
    wire sel_st = (reg_addr_i == apmc_pkg::STATUS_OFFSET);

    // Busy until the link echoes the toggle
    wire cfg_busy = (req_tgl_reg != ack_s2_reg);
    // Unsupported codes are reported, not applied
    wire fallback = (sap_cfg_reg.format == 3'h7) || (sap_cfg_reg.rate == 2'h3)
                    || (mod_cfg_reg.pwm_freq == 3'h2) || (mod_cfg_reg.pwm_freq == 3'h3)
                    || (mod_cfg_reg.pwm_freq == 3'h4)
                    || ((mod_cfg_reg.pwm_freq == apmc_pkg::PWM_X48)
                        && (sap_cfg_reg.rate == apmc_pkg::RATE_48K));
    wire [7:0] status_word = {5'h00, fallback, frame_seen_reg, cfg_busy};
    wire [7:0] rd_mux = sel_mod ? mod_cfg_reg
                      : sel_sap ? sap_cfg_reg
                      : sel_st ? status_word
                      : apmc_pkg::ZERO_BYTE;

    // A newer value waits for the running handshake
    wire cfg_load = ~cfg_busy && (cfg_hold_reg != sap_eff);
    // Edge taken between two clean stages
    wire frm_event = frm_s2_reg ^ frm_s3_reg;

    // Reserved codes are replaced before crossing
    assign sap_eff = '{rate: safe_rate(sap_cfg_reg.rate),
                       slot_group: sap_cfg_reg.slot_group,
                       slot16: sap_cfg_reg.slot16,
                       swap: sap_cfg_reg.swap,
                       format: safe_format(sap_cfg_reg.format)};

    // Registers; reserved modulator bits are never stored
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sap_cfg_reg <= apmc_pkg::SAP_CFG_RESET;
            mod_cfg_reg <= apmc_pkg::MOD_CFG_RESET;
        end
        else if (reg_wr_i)
        begin
            if (sel_sap)
            begin
                sap_cfg_reg <= reg_wdata_i;
            end
            if (sel_mod)
            begin
                mod_cfg_reg <= reg_wdata_i & apmc_pkg::MOD_CFG_WMASK;
            end
        end
    end

    // Read data stands for exactly one cycle
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata_reg <= apmc_pkg::ZERO_BYTE;
        end
        else
        begin
            rdata_reg <= reg_rd_i ? rd_mux : apmc_pkg::ZERO_BYTE;
        end
    end

    // Modulator settings follow the registers one cycle later
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pwm_mult_reg <= apmc_pkg::MULT_44;
            osr_reg <= apmc_pkg::OSR_64;
            phase_reg <= apmc_pkg::PHASE_45;
            fs_hz_reg <= apmc_pkg::FS_44K1_HZ;
        end
        else
        begin
            pwm_mult_reg <= pwm_mult(mod_cfg_reg.pwm_freq, sap_eff.rate);
            osr_reg <= mod_cfg_reg.osr ? apmc_pkg::OSR_128 : apmc_pkg::OSR_64;
            phase_reg <= phase_deg(mod_cfg_reg.phase);
            fs_hz_reg <= fs_hz(sap_eff.rate);
        end
    end

    // Word crossing by toggle handshake; the held word is steady while busy
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_hold_reg <= apmc_pkg::SAP_CFG_RESET;
            req_tgl_reg <= 1'b0;
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end
        else
        begin
            ack_s1_reg <= req_seen_reg;
            ack_s2_reg <= ack_s1_reg;
            if (cfg_load)
            begin
                cfg_hold_reg <= sap_eff;
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    // Link reset asserts at once and releases on the bit clock
    always_ff @(posedge sclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_l1_reg <= 1'b0;
            rst_l2_reg <= 1'b0;
        end
        else
        begin
            rst_l1_reg <= 1'b1;
            rst_l2_reg <= rst_l1_reg;
        end
    end

    // A stopped bit clock only delays the update until it runs again
    always_ff @(posedge sclk_i or negedge rst_l2_reg)
    begin
        if (!rst_l2_reg)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            cfg_link_reg <= apmc_pkg::SAP_CFG_RESET;
        end
        else
        begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            if (req_s2_reg != req_seen_reg)
            begin
                cfg_link_reg <= cfg_hold_reg;
                req_seen_reg <= req_s2_reg;
            end
        end
    end

    // Receiver runs wholly on the bit clock
    apmc_sap_rx u_rx
    (
        .sclk_i(sclk_i),
        .rstn_link_i(rst_l2_reg),
        .fsync_i(fsync_i),
        .sdata_i(sdata_i),
        .cfg_i(cfg_link_reg),
        .frame_o(rx_frame),
        .frame_tgl_o(rx_tgl)
    );

    // Frame crossing: toggle synchronised, frame word read after it settles
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            frm_s1_reg <= 1'b0;
            frm_s2_reg <= 1'b0;
            frm_s3_reg <= 1'b0;
            frame_reg <= '0;
            frame_valid_reg <= 1'b0;
            frame_seen_reg <= 1'b0;
        end
        else
        begin
            frm_s1_reg <= rx_tgl;
            frm_s2_reg <= frm_s1_reg;
            frm_s3_reg <= frm_s2_reg;
            frame_valid_reg <= frm_event;
            if (frm_event)
            begin
                frame_reg <= rx_frame;
                frame_seen_reg <= 1'b1;
            end
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata_o = rdata_reg;
    assign pwm_mult_o = pwm_mult_reg;
    assign sigma_delta_oversampling_select_o = osr_reg;
    assign phase_deg_o = phase_reg;
    assign fs_hz_o = fs_hz_reg;
    assign frame_o = frame_reg;
    assign frame_valid_o = frame_valid_reg;

endmodule : apmc_top

// ### test/apmc_top_assertions.sv
// Checker for apmc_top: register read-back and settings outputs.
// Assumes it is bound to apmc_top and sees only its ports.
module apmc_chk
(
    // Clocks and reset
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Serial link
    input wire logic fsync_i,
    input wire logic [1:0] sdata_i,
    // Settings and frames
    input wire logic [5:0] pwm_mult_o,
    input wire logic [7:0] sigma_delta_oversampling_select_o,
    input wire logic [5:0] phase_deg_o,
    input wire logic [16:0] fs_hz_o,
    input wire apmc_pkg::apmc_frame_t frame_o,
    input wire logic frame_valid_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    logic [7:0] mod_q;
    logic [7:0] sap_q;
    logic [2:0] quiet;
    wire wr_mod = reg_wr_i && reg_addr_i == 8'h02;
    wire [1:0] rate = sap_q[7:6];
    wire [2:0] pc = mod_q[6:4];
    // Code 111 is not allowed at 48 kHz and falls back to 44x
    wire [5:0] exp_mult = pc == 3'h0 ? 6'h08 : pc == 3'h1 ? 6'h0A : pc == 3'h5 ? 6'h26 :
        (pc == 3'h7 && rate != 2'h1) ? 6'h30 : 6'h2C;
    wire [5:0] exp_ph = mod_q[1] ? (mod_q[0] ? 6'h3C : 6'h2D) : (mod_q[0] ? 6'h1E : 6'h00);
    wire [16:0] exp_fs = rate == 2'h1 ? 17'h0_BB80 : rate == 2'h2 ? 17'h1_7700 : 17'h0_AC44;
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mod_q <= 8'h62;
            sap_q <= 8'h04;
            quiet <= 3'h0;
        end
        else
        begin
            if (wr_mod)
                mod_q <= reg_wdata_i & 8'h77;
            if (reg_wr_i && reg_addr_i == 8'h03)
                sap_q <= reg_wdata_i;
            quiet <= reg_wr_i ? 3'h0 : (quiet == 3'h7 ? quiet : quiet + 3'h1);
        end
    end
    AST_UNMAPPED_READ: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h02, 8'h03, 8'h30}) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read returned data");
    AST_MOD_READBACK: assert property (
        reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o == $past(mod_q))
        else $error("modulator config read-back wrong");
    AST_SAP_READBACK: assert property (
        reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == $past(sap_q))
        else $error("serial port config read-back wrong");
    AST_PWM_MULT: assert property (
        quiet > 3'h3 |-> pwm_mult_o == exp_mult)
        else $error("switching multiple does not follow its code");
    AST_OSR_LATENCY: assert property (
        wr_mod ##1 !reg_wr_i |=> sigma_delta_oversampling_select_o == (mod_q[2] ? 8'h80 : 8'h40))
        else $error("oversampling ratio late or wrong");
    AST_PHASE: assert property (
        quiet > 3'h3 |-> phase_deg_o == exp_ph)
        else $error("phase offset does not follow its code");
    AST_RATE: assert property (
        quiet > 3'h3 |-> fs_hz_o == exp_fs)
        else $error("sample rate does not follow its code");
    AST_FRAME_HOLD: assert property (
        !frame_valid_o |-> $stable(frame_o))
        else $error("frame changed without a valid pulse");
    AST_VALID_PULSE: assert property (
        frame_valid_o |=> !frame_valid_o)
        else $error("frame valid longer than one cycle");
endmodule : apmc_chk

bind apmc_top apmc_chk u_chk (.mclk_i, .resetn_i, .sclk_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fsync_i, .sdata_i, .pwm_mult_o, .sigma_delta_oversampling_select_o,
    .phase_deg_o, .fs_hz_o, .frame_o, .frame_valid_o);

// ### test/apmc_audio_src.sv
// Audio source model: bit clock, frame sync and two data lines.
// Assumes the receiver samples on the rising bit-clock edge.
module apmc_audio_src
(
    // Serial link
    output logic sclk_o,
    output logic fsync_o,
    output logic [1:0] sdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        sclk_o = 1'b0;
        fsync_o = 1'b1;
        sdata_o = 2'h0;
    end
    // Whole frames only; the bit clock stands still between calls
    task automatic send(input logic [2:0] fmt, input logic s16, input logic [7:0][23:0] smp,
        input int nfr);
        int w;
        int off;
        int st;
        int q;
        int h;
        int p;
        logic tdm;
        logic ok;
        tdm = fmt == 3'h6;
        w = fmt == 3'h1 ? 20 : fmt == 3'h2 ? 18 : fmt == 3'h3 || (tdm && s16) ? 16 : 24;
        off = fmt == 3'h5 || tdm ? 0 : fmt < 3'h4 ? 32 - w : 1;
        st = tdm && s16 ? 16 : 32;
        #3;
        repeat (nfr)
        begin
            for (int j = 0; j < (tdm ? 8 * st : 64); j++)
            begin
                q = tdm ? (j + 8 * st - 1) % (8 * st) : j;
                h = q / st;
                p = q % st - off;
                ok = p >= 0 && p < w;
                fsync_o = tdm ? j == 0 : (h == 1) ^ (fmt != 3'h4);
                sdata_o[0] = ok ? smp[h][23 - p] : 1'b1;
                sdata_o[1] = tdm ? ~sdata_o[1] : ok ? smp[h + 2][23 - p] : 1'b1;
                #62.5 sclk_o = 1'b1;
                #62.5 sclk_o = 1'b0;
            end
        end
        // Released lines show no stale level
        sdata_o = ~sdata_o;
    endtask : send
endmodule : apmc_audio_src

// ### test/apmc_top_bench.sv
// Self-checking bench for apmc_top, with the audio source model on the link.
// Assumes read data stand only in the cycle after the read strobe.
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module apmc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i;
    logic resetn_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic reg_wr_i;
    logic reg_rd_i;
    logic [7:0] reg_rdata_o;
    logic sclk_i;
    logic fsync_i;
    logic [1:0] sdata_i;
    logic [5:0] pwm_mult_o;
    logic [7:0] sigma_delta_oversampling_select_o;
    logic [5:0] phase_deg_o;
    logic [16:0] fs_hz_o;
    apmc_pkg::apmc_frame_t frame_o;
    logic frame_valid_o;
    int fails;
    int num_checks;
    logic [7:0][23:0] smp;
    apmc_top uut (.mclk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .sclk_i, .fsync_i, .sdata_i, .pwm_mult_o, .sigma_delta_oversampling_select_o, .phase_deg_o,
        .fs_hz_o, .frame_o, .frame_valid_o);
    apmc_audio_src src (.sclk_o(sclk_i), .fsync_o(fsync_i), .sdata_o(sdata_i));
    initial
    begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : wait_clk
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : reg_read
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    task automatic t_reset_values;
        logic [7:0] d;
        reg_read(8'h02, d);
        `CHK("mod_cfg reset", 8'h62, d);
        reg_read(8'h03, d);
        `CHK("sap_cfg reset", 8'h04, d);
        `CHK("switching multiple", 6'h2C, pwm_mult_o);
        `CHK("oversampling", 8'h40, sigma_delta_oversampling_select_o);
        `CHK("phase", 6'h2D, phase_deg_o);
        `CHK("sample rate", 17'h0_AC44, fs_hz_o);
        $display("reset values done");
    endtask : t_reset_values
    task automatic t_modulator;
        logic [7:0] d;
        logic [7:0] v;
        logic [5:0] mult [8] = '{6'h08, 6'h0A, 6'h2C, 6'h2C, 6'h2C, 6'h26, 6'h2C, 6'h30};
        logic [5:0] ph [4] = '{6'h00, 6'h1E, 6'h2D, 6'h3C};
        for (int i = 0; i < 8; i++)
        begin
            v = {1'b0, 3'(i), 1'b0, 1'(i), 2'(i)};
            reg_write(8'h02, v | 8'h88);
            wait_clk(6);
            reg_read(8'h02, d);
            `CHK("mod_cfg readback", v, d);
            `CHK("switching multiple", mult[i], pwm_mult_o);
            `CHK("oversampling", i[0] ? 8'h80 : 8'h40, sigma_delta_oversampling_select_o);
            `CHK("phase", ph[i % 4], phase_deg_o);
        end
        reg_write(8'h03, 8'h44);
        wait_clk(6);
        `CHK("48x at 48 kHz", 6'h2C, pwm_mult_o);
        reg_write(8'h02, 8'h62);
        $display("modulator done");
    endtask : t_modulator
    task automatic t_rates;
        logic [7:0] d;
        logic [16:0] fs [4] = '{17'h0_AC44, 17'h0_BB80, 17'h1_7700, 17'h0_AC44};
        for (int r = 0; r < 4; r++)
        begin
            reg_write(8'h03, {2'(r), 6'h04});
            wait_clk(6);
            reg_read(8'h03, d);
            `CHK("sap_cfg readback", {2'(r), 6'h04}, d);
            `CHK("sample rate", fs[r], fs_hz_o);
        end
        reg_write(8'h03, 8'h04);
        reg_write(8'h45, 8'hA5);
        reg_read(8'h45, d);
        `CHK("unmapped read", 8'h00, d);
        reg_read(8'h03, d);
        `CHK("sap_cfg after unmapped write", 8'h04, d);
        $display("rates done");
    endtask : t_rates
    // First frame only primes the link, since settings cross while it runs
    task automatic run_frame(input logic [7:0] cfg, input int w, input int base);
        logic [23:0] m;
        reg_write(8'h03, cfg);
        src.send(cfg[2:0], cfg[4], smp, 3);
        m = 24'hFF_FFFF << (24 - w);
        for (int k = 0; k < 4; k++)
            `CHK("frame channel", smp[(cfg[3] ? k ^ 2 : k) + base] & m, frame_o[k]);
    endtask : run_frame
    task automatic t_serial_formats;
        int wd [4] = '{24, 20, 18, 16};
        run_frame(8'h04, 24, 0);
        run_frame(8'h0C, 24, 0);
        run_frame(8'h05, 24, 0);
        for (int f = 0; f < 4; f++)
            run_frame({5'h00, 3'(f)}, wd[f], 0);
        $display("serial formats done");
    endtask : t_serial_formats
    task automatic t_tdm;
        logic [7:0] d;
        run_frame(8'h06, 24, 0);
        run_frame(8'h26, 24, 4);
        run_frame(8'h16, 16, 0);
        run_frame(8'h36, 16, 4);
        reg_read(8'h30, d);
        `CHK("status", 8'h02, d);
        $display("tdm done");
    endtask : t_tdm
    // Whole run is about half a millisecond
    initial
    begin
        #1_000_000;
        fails++;
        finish_test();
    end
    initial
    begin
        resetn_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        fails = 0;
        num_checks = 0;
        smp = {24'h9A_5C3E, 24'h6E_81D7, 24'hC3_0F5A, 24'h2B_E694,
            24'hF1_7A28, 24'h45_B3C9, 24'h8D_16E0, 24'h37_D24B};
        fork
            src.send(3'h4, 1'b0, smp, 1);
            begin
                repeat (20) @(posedge mclk_i);
                resetn_i <= 1'b1;
            end
        join
        t_reset_values();
        t_modulator();
        t_rates();
        t_serial_formats();
        t_tdm();
        finish_test();
    end
endmodule : apmc_top_bench
